// ==== include/sleep_wakeup_pkg.sv ====
// Package for the sleep and wake-up controller: register map, field layout, timing.
// Assumes a 50 MHz system clock and a plain strobe register port.
package sleep_wakeup_pkg;

    // Register addresses on the plain register port
    localparam logic [3:0] ADDR_REGULATOR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CORE_STATUS = 4'h1;
    localparam logic [3:0] ADDR_CONFIG = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;

    // Regulator control fields
    localparam int REG_PM_BIT = 1;
    localparam int REG_RSVD_BIT = 0;
    localparam logic REG_PM_RESET = 1'h0;
    localparam logic REG_RSVD_RESET = 1'h1;

    // Core status fields
    localparam int STAT_TO_BIT = 4;
    localparam int STAT_PD_BIT = 3;

    // Configuration register fields
    localparam int CFG_XTAL_BIT = 0;
    localparam int CFG_TWO_SPEED_BIT = 1;
    localparam int CFG_EXT_RESET_EN_BIT = 2;
    localparam int CFG_BROWNOUT_EN_BIT = 3;
    localparam int CFG_WATCHDOG_EN_BIT = 4;
    localparam logic [7:0] CFG_RESET = 8'h1C;

    // Event status bits
    localparam int EV_WAKE_IRQ = 0;
    localparam int EV_WAKE_WDOG = 1;
    localparam int EV_SLEEP_NOP = 2;
    localparam int EV_SLEEP_ENTER = 3;

    // Interrupt sources
    localparam int NUM_SRC = 8;

    // Oscillator start-up delay: 1024 oscillator periods
    localparam int OST_PERIODS = 1024;
    localparam logic [10:0] OST_CYCLES = 11'(OST_PERIODS);

    // Extra regulator stabilisation delay after low-power sleep
    localparam int REG_STAB_NS = 5000;
    localparam int CLK_PERIOD_NS = 20;
    localparam logic [10:0] REG_STAB_CYCLES = 11'((REG_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Interrupt vector address
    localparam logic [12:0] ISR_VECTOR = 13'h0004;

    typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_REG_WAIT, ST_OST_WAIT, ST_RESUME} state_e;

    // Register port request bundle
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

// ==== src/sleep_wakeup_control.sv ====
// Sleep and wake-up controller: sleep entry, wake sources, status flags, start-up delays.
// Assumes the core asserts sleep_exec for one cycle per sleep instruction and that reset
// sources arrive asynchronously from pins or analog monitors.
//
// Behaviour
// - Leave sleep on reset pin, brown-out, power-on, watchdog, or enabled interrupt.
// - Pin, brown-out and power-on wake-ups reset; watchdog and interrupt wakes resume.
// - Prefetch instruction at program counter plus one while sleep executes; the code shows that address one cycle after the request.
// - Interrupt wakes only if its enable is set, regardless of global enable.
// - Global enable clear continues in line; set runs next instruction then vectors 0004h.
// - Clear the watchdog on every wake-up from sleep.
// - Interrupt pending before sleep with global off: sleep is a no-op, flags untouched.
// - Interrupt during sleep with global off: complete sleep, wake, clear watchdog, set flags.
// - Crystal modes wait 1024 oscillator periods on wake unless two-speed start-up is set; other modes skip it.
// - Power select bit set puts regulator in low-power state during sleep.
// - Waking from low-power sleep adds a stabilisation delay; normal mode does not.
// - Keep regulator in normal power while an incompatible peripheral is enabled.
// - Power select bit resets to zero, selecting normal-power sleep.
// - Regulator control bits 7..2 read zero; bit 0 reads one after reset.
// - Entering sleep clears powerdown flag, sets timeout flag, stops the core clock.
// - Interrupt flags set on their condition regardless of any enable.
module sleep_wakeup_control
    import sleep_wakeup_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    input wire logic sleep_exec,
    input wire logic [12:0] program_counter,
    input wire logic global_irq_enable,
    input wire logic [NUM_SRC-1:0] irq_event,
    input wire logic external_reset_pin_n,
    input wire logic brownout_reset,
    input wire logic poweron_reset,
    input wire logic watchdog_timeout,
    input wire logic lp_incompatible_periph,
    output logic core_clk_en,
    output logic [12:0] prefetch_addr,
    output logic prefetch_req,
    output logic vector_req,
    output logic [12:0] vector_addr,
    output logic watchdog_clear,
    output logic device_reset,
    output logic regulator_low_power
);

    ////////////////////////////////////////////////////////////////////////////
    // Register port bundle
    reg_req_s req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Sequencer state
    state_e state_r;
    // Regulator control bits
    logic regulator_sleep_power_select_r;
    logic rsvd_r;
    // Core status flags, both set by any reset
    logic timeout_flag_r;
    logic powerdown_flag_r;
    // Configuration, event status and event mask
    logic [7:0] cfg_r;
    logic [3:0] ev_status_r;
    logic [3:0] ev_mask_r;
    // Interrupt flags and their enables
    logic [NUM_SRC-1:0] irq_flag_r;
    logic [NUM_SRC-1:0] irq_enable_r;
    // Countdown shared by both start-up delays
    logic [10:0] delay_cnt_r;
    // Vector owed in the resume cycle
    logic vector_pend_r;
    // Synchroniser chains, oldest sample in bit 2
    logic [2:0] pin_sync_r;
    logic [2:0] bor_sync_r;
    logic [2:0] por_sync_r;
    logic [2:0] wdt_sync_r;
    // Address of the instruction after sleep
    logic [12:0] prefetch_addr_r;

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers for asynchronous reset and watchdog sources
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_sync_r <= 3'h0;
            bor_sync_r <= 3'h0;
            por_sync_r <= 3'h0;
            wdt_sync_r <= 3'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], ~external_reset_pin_n};
            bor_sync_r <= {bor_sync_r[1:0], brownout_reset};
            por_sync_r <= {por_sync_r[1:0], poweron_reset};
            wdt_sync_r <= {wdt_sync_r[1:0], watchdog_timeout};
        end
    end

    // A source counts as asserted once stages two and three are both high; it drops when either falls
    logic pin_rst;
    logic bor_rst;
    logic por_rst;
    logic wdt_evt;
    assign pin_rst = pin_sync_r[1] & pin_sync_r[2] & cfg_r[CFG_EXT_RESET_EN_BIT];
    assign bor_rst = bor_sync_r[1] & bor_sync_r[2] & cfg_r[CFG_BROWNOUT_EN_BIT];
    assign por_rst = por_sync_r[1] & por_sync_r[2];
    assign wdt_evt = wdt_sync_r[1] & wdt_sync_r[2] & cfg_r[CFG_WATCHDOG_EN_BIT];

    // Full device reset sources, asleep or awake
    assign device_reset = pin_rst | bor_rst | por_rst;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt wake request
    logic wake_irq;
    assign wake_irq = |(irq_flag_r & irq_enable_r);

    // Sleep entry decision
    logic sleep_as_nop;
    logic sleep_enter;
    assign sleep_as_nop = sleep_exec && state_r == ST_RUN && wake_irq && !global_irq_enable;
    assign sleep_enter = sleep_exec && state_r == ST_RUN && !sleep_as_nop;

    // Wake decision while asleep
    logic wake_now;
    assign wake_now = state_r == ST_SLEEP && (wake_irq || wdt_evt);

    // Whether the regulator really dropped to low power
    logic lp_active;
    assign lp_active = regulator_sleep_power_select_r && !lp_incompatible_periph;

    ////////////////////////////////////////////////////////////////////////////
    // Sleep / wake sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_RUN;
            delay_cnt_r <= 11'h000;
        end else if (device_reset) begin
            state_r <= ST_RUN;
            delay_cnt_r <= 11'h000;
        end else begin
            case (state_r)
                ST_RUN: begin
                    // A no-op sleep leaves the core running
                    if (sleep_enter) begin
                        state_r <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    // Regulator delay first, crystal start-up after it
                    if (wake_now) begin
                        if (lp_active) begin
                            state_r <= ST_REG_WAIT;
                            delay_cnt_r <= REG_STAB_CYCLES;
                        end else if (cfg_r[CFG_XTAL_BIT] && !cfg_r[CFG_TWO_SPEED_BIT]) begin
                            state_r <= ST_OST_WAIT;
                            delay_cnt_r <= OST_CYCLES;
                        end else begin
                            state_r <= ST_RESUME;
                        end
                    end
                end
                ST_REG_WAIT: begin
                    // Count down, then hand over to the crystal wait if one is due
                    if (delay_cnt_r <= 11'h001) begin
                        if (cfg_r[CFG_XTAL_BIT] && !cfg_r[CFG_TWO_SPEED_BIT]) begin
                            state_r <= ST_OST_WAIT;
                            delay_cnt_r <= OST_CYCLES;
                        end else begin
                            state_r <= ST_RESUME;
                        end
                    end else begin
                        delay_cnt_r <= delay_cnt_r - 11'h001;
                    end
                end
                ST_OST_WAIT: begin
                    // Core clock stays stopped until the crystal has settled
                    if (delay_cnt_r <= 11'h001) begin
                        state_r <= ST_RESUME;
                    end else begin
                        delay_cnt_r <= delay_cnt_r - 11'h001;
                    end
                end
                ST_RESUME: begin
                    // One cycle for the prefetched instruction, then run
                    state_r <= ST_RUN;
                end
                default: begin
                    // Unused codes fall back to run
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // Core clock stops from sleep entry until the resume cycle
    assign core_clk_en = state_r == ST_RUN || state_r == ST_RESUME;
    // Regulator low power only while truly asleep
    assign regulator_low_power = state_r == ST_SLEEP && lp_active;
    // Watchdog held clear on entry, on any wake (a reset wake too) and through the start-up delay
    assign watchdog_clear = sleep_enter || wake_now || device_reset || state_r == ST_REG_WAIT ||
        state_r == ST_OST_WAIT;

    ////////////////////////////////////////////////////////////////////////////
    // Prefetch of the instruction after sleep
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prefetch_addr_r <= 13'h0000;
        end else if (sleep_exec) begin
            prefetch_addr_r <= program_counter + 13'h0001;
        end
    end
    // Request stands only in the cycle of the sleep instruction
    assign prefetch_addr = prefetch_addr_r;
    assign prefetch_req = sleep_exec;

    // Vector after the following instruction when global interrupts are on
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vector_pend_r <= 1'b0;
        end else if (device_reset) begin
            vector_pend_r <= 1'b0;
        end else if (wake_now && wake_irq) begin
            vector_pend_r <= global_irq_enable;
        end else if (state_r == ST_RESUME) begin
            vector_pend_r <= 1'b0;
        end
    end
    assign vector_req = state_r == ST_RESUME && vector_pend_r;
    assign vector_addr = ISR_VECTOR;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flags: set by condition, cleared by a one written to the enable address;
    // a condition in the same cycle as the clear wins
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_flag
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    irq_flag_r[gi] <= 1'b0;
                end else if (irq_event[gi]) begin
                    irq_flag_r[gi] <= 1'b1;
                end else if (req.wr && req.addr == ADDR_IRQ_ENABLE && req.wdata[gi]) begin
                    irq_flag_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Core status flags: any reset sets both; entry clears powerdown and sets timeout;
    // a watchdog-only wake clears timeout, an interrupt wake (with or without the watchdog) leaves both as entry left them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timeout_flag_r <= 1'b1;
            powerdown_flag_r <= 1'b1;
        end else if (device_reset) begin
            timeout_flag_r <= 1'b1;
            powerdown_flag_r <= 1'b1;
        end else if (sleep_enter) begin
            timeout_flag_r <= 1'b1;
            powerdown_flag_r <= 1'b0;
        end else if (wake_now && wdt_evt && !wake_irq) begin
            timeout_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regulator_sleep_power_select_r <= REG_PM_RESET;
            rsvd_r <= REG_RSVD_RESET;
            cfg_r <= CFG_RESET;
            ev_mask_r <= 4'h0;
            irq_enable_r <= '0;
        end else if (req.wr) begin
            case (req.addr)
                ADDR_REGULATOR_CONTROL: begin
                    regulator_sleep_power_select_r <= req.wdata[REG_PM_BIT];
                    rsvd_r <= req.wdata[REG_RSVD_BIT];
                end
                ADDR_CONFIG: cfg_r <= req.wdata;
                ADDR_IRQ_MASK: ev_mask_r <= req.wdata[3:0];
                ADDR_IRQ_ENABLE: irq_enable_r <= req.wdata;
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky event status, cleared by read; a new event wins
    logic [3:0] ev_set;
    assign ev_set = {sleep_enter, sleep_as_nop, wake_now && wdt_evt, wake_now && wake_irq};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ev_status_r <= 4'h0;
        end else if (req.rd && req.addr == ADDR_IRQ_STATUS) begin
            ev_status_r <= ev_set;
        end else begin
            ev_status_r <= ev_status_r | ev_set;
        end
    end
    assign irq = |(ev_status_r & ev_mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the read strobe
    // Unmapped addresses and idle cycles read zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_REGULATOR_CONTROL: reg_rdata <= {6'h00, regulator_sleep_power_select_r, rsvd_r};
                ADDR_CORE_STATUS: reg_rdata <= {3'h0, timeout_flag_r, powerdown_flag_r, 3'h0};
                ADDR_CONFIG: reg_rdata <= cfg_r;
                ADDR_IRQ_STATUS: reg_rdata <= {4'h0, ev_status_r};
                ADDR_IRQ_MASK: reg_rdata <= {4'h0, ev_mask_r};
                ADDR_IRQ_ENABLE: reg_rdata <= irq_flag_r;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ==== verif/sleep_wakeup_properties.sv ====
// Checker for the sleep and wake-up controller, watching its top-level ports.
// Assumes one clock domain and is attached by the bind at the foot of this file.
module sleep_wakeup_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sleep_exec,
    input wire logic [12:0] program_counter,
    input wire logic global_irq_enable,
    input wire logic poweron_reset,
    input wire logic lp_incompatible_periph,
    input wire logic core_clk_en,
    input wire logic [12:0] prefetch_addr,
    input wire logic prefetch_req,
    input wire logic vector_req,
    input wire logic [12:0] vector_addr,
    input wire logic watchdog_clear,
    input wire logic device_reset,
    input wire logic regulator_low_power
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Steps of sleep entry and of the low-power recovery wait
    sequence seq_enter;
        ##1 !core_clk_en;
    endsequence
    sequence seq_stab;
        !core_clk_en [*8];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    chk_prefetch_addr: assert property (sleep_exec |=> prefetch_addr == $past(program_counter) + 13'h1)
        else $error("prefetch address is not sleep address plus one");
    chk_prefetch_req: assert property (sleep_exec |-> prefetch_req)
        else $error("no prefetch while sleep executes");
    chk_vector_addr: assert property (vector_req |-> vector_addr == 13'h0004)
        else $error("vector address wrong");
    chk_vector_cause: assert property (vector_req |-> global_irq_enable && !$past(core_clk_en))
        else $error("vector request without wake or global enable");
    chk_enter_cause: assert property ($fell(core_clk_en) |-> $past(sleep_exec) && $past(watchdog_clear))
        else $error("core clock stopped without sleep or watchdog clear");
    chk_sleep_enter: assert property (sleep_exec && core_clk_en && global_irq_enable && !device_reset |-> seq_enter)
        else $error("sleep with global enable did not stop core clock");
    chk_wake_clear: assert property ($rose(core_clk_en) && !device_reset |-> $past(watchdog_clear))
        else $error("wake without watchdog clear");
    chk_lp_blocked: assert property (lp_incompatible_periph |-> !regulator_low_power)
        else $error("low power with incompatible peripheral");
    chk_lp_asleep: assert property (regulator_low_power |-> !core_clk_en)
        else $error("low power while core runs");
    chk_lp_stab: assert property ($fell(regulator_low_power) && !lp_incompatible_periph && !device_reset |-> seq_stab)
        else $error("no stabilisation wait after low power sleep");
    chk_por_reset: assert property ($rose(poweron_reset) |-> ##[2:4] device_reset)
        else $error("power-on did not reset device");
endmodule

bind sleep_wakeup_control sleep_wakeup_properties sleep_wakeup_properties_i (.clk(clk), .resetn(resetn),
    .sleep_exec(sleep_exec), .program_counter(program_counter), .global_irq_enable(global_irq_enable),
    .poweron_reset(poweron_reset), .lp_incompatible_periph(lp_incompatible_periph), .core_clk_en(core_clk_en),
    .prefetch_addr(prefetch_addr), .prefetch_req(prefetch_req), .vector_req(vector_req),
    .vector_addr(vector_addr), .watchdog_clear(watchdog_clear), .device_reset(device_reset),
    .regulator_low_power(regulator_low_power));

// ==== verif/core_model.sv ====
// Processor core model driving the sleep link of the controller.
// Assumes the bench calls do_sleep; a stopped core clock holds the core still.
module core_model (
    input wire logic clk,
    input wire logic core_clk_en,
    output logic sleep_exec,
    output logic [12:0] program_counter
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle core executing ordinary code
    initial begin
        sleep_exec = 1'b0;
        program_counter = 13'h0100;
    end
    // One sleep instruction, issued only while the core clock runs
    task automatic do_sleep(input logic [12:0] pc);
        @(negedge clk);
        while (core_clk_en !== 1'b1) @(negedge clk);
        @(posedge clk);
        sleep_exec <= 1'b1;
        program_counter <= pc;
        @(posedge clk);
        sleep_exec <= 1'b0;
        program_counter <= pc + 13'h1;
    endtask
endmodule

// ==== verif/tb_sleep_wakeup_control.sv ====
// Testbench for the sleep and wake-up controller.
// Assumes the core model drives the sleep link and the checker is bound.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb_sleep_wakeup_control
    import sleep_wakeup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, global_irq_enable = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, irq_event = 8'h00, reg_rdata;
    logic external_reset_pin_n = 1'b1, brownout_reset = 1'b0, poweron_reset = 1'b0;
    logic watchdog_timeout = 1'b0, lp_incompatible_periph = 1'b0, vec_seen = 1'b0;
    logic irq, sleep_exec, core_clk_en, vector_req, watchdog_clear, device_reset, regulator_low_power;
    logic [12:0] program_counter, prefetch_addr, vector_addr;
    int n_mismatch = 0, compares = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    always #10 clk = ~clk;
    sleep_wakeup_control sleep_wakeup_control_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .sleep_exec(sleep_exec), .program_counter(program_counter), .global_irq_enable(global_irq_enable),
        .irq_event(irq_event), .external_reset_pin_n(external_reset_pin_n), .brownout_reset(brownout_reset),
        .poweron_reset(poweron_reset), .watchdog_timeout(watchdog_timeout),
        .lp_incompatible_periph(lp_incompatible_periph), .core_clk_en(core_clk_en),
        .prefetch_addr(prefetch_addr), .prefetch_req(), .vector_req(vector_req), .vector_addr(vector_addr),
        .watchdog_clear(watchdog_clear), .device_reset(device_reset), .regulator_low_power(regulator_low_power));
    core_model core_model_i (.clk(clk), .core_clk_en(core_clk_en), .sleep_exec(sleep_exec),
        .program_counter(program_counter));
    // Vector capture and run ceiling
    always @(posedge clk) begin
        if (vector_req === 1'b1) vec_seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_mismatch++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Register port cycles and event helpers
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        `CHK(reg_rdata, e)
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge clk);
        irq_event <= v;
        @(posedge clk);
        irq_event <= 8'h00;
    endtask
    task automatic wait_wake(input int lo, input int hi);
        int n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (core_clk_en !== 1'b1 && n < 1100);
        `CHK(n >= lo && n <= hi, 1'b1)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        rd(ADDR_REGULATOR_CONTROL, 8'h01);
        rd(ADDR_CORE_STATUS, 8'h18);
        rd(4'hF, 8'h00);
        wr(ADDR_REGULATOR_CONTROL, 8'hFF);
        rd(ADDR_REGULATOR_CONTROL, 8'h03);
        wr(ADDR_REGULATOR_CONTROL, 8'h01);
    endtask
    task automatic t_nop();
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_IRQ_MASK, 8'h09);
        pulse(8'h01);
        core_model_i.do_sleep(13'h0120);
        @(negedge clk);
        `CHK(core_clk_en, 1'b1)
        `CHK(irq, 1'b0)
        rd(ADDR_CORE_STATUS, 8'h18);
        rd(ADDR_IRQ_STATUS, 8'h04);
        wr(ADDR_IRQ_ENABLE, 8'h01);
    endtask
    task automatic t_irq_wake(input logic g);
        @(posedge clk);
        global_irq_enable <= g;
        vec_seen = 1'b0;
        core_model_i.do_sleep(13'h0140);
        @(negedge clk);
        `CHK(core_clk_en, 1'b0)
        `CHK(irq, 1'b1)
        rd(ADDR_CORE_STATUS, 8'h10);
        rd(ADDR_IRQ_STATUS, 8'h08);
        pulse(8'h02);
        repeat (4) @(negedge clk);
        `CHK(core_clk_en, 1'b0)
        rd(ADDR_IRQ_ENABLE, 8'h02);
        pulse(8'h01);
        wait_wake(1, 4);
        repeat (3) @(negedge clk);
        `CHK(vec_seen, g)
        `CHK(irq, 1'b1)
        rd(ADDR_CORE_STATUS, 8'h10);
        rd(ADDR_IRQ_STATUS, 8'h01);
        `CHK(irq, 1'b0)
        wr(ADDR_IRQ_ENABLE, 8'h03);
        wr(ADDR_IRQ_ENABLE, 8'h01);
    endtask
    task automatic t_wdog();
        core_model_i.do_sleep(13'h0160);
        @(posedge clk);
        watchdog_timeout <= 1'b1; // Held until the synchroniser stages agree
        repeat (3) @(posedge clk);
        watchdog_timeout <= 1'b0;
        wait_wake(2, 8);
        `CHK(device_reset, 1'b0)
        rd(ADDR_CORE_STATUS, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h0A);
    endtask
    task automatic t_delay(input logic [7:0] rv, input logic [7:0] cv, input int lo, input int hi);
        wr(ADDR_REGULATOR_CONTROL, rv);
        wr(ADDR_CONFIG, cv);
        core_model_i.do_sleep(13'h0180);
        @(negedge clk);
        `CHK(regulator_low_power, rv[1])
        @(posedge clk);
        lp_incompatible_periph <= 1'b1;
        @(negedge clk);
        `CHK(regulator_low_power, 1'b0)
        @(posedge clk);
        lp_incompatible_periph <= 1'b0;
        pulse(8'h01);
        wait_wake(lo, hi);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        rd(ADDR_IRQ_STATUS, 8'h09);
    endtask
    task automatic t_reset();
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CONFIG, k == 3 ? 8'h14 : 8'h1C);
            if (k < 3) core_model_i.do_sleep(13'h01A0);
            @(posedge clk);
            {external_reset_pin_n, brownout_reset, poweron_reset} <= k == 3 ? 3'b110 : 3'b100 ^ (3'b100 >> k);
            repeat (6) @(negedge clk);
            `CHK(device_reset, k < 3)
            @(posedge clk);
            {external_reset_pin_n, brownout_reset, poweron_reset} <= 3'b100;
            repeat (6) @(negedge clk);
            `CHK(core_clk_en, 1'b1)
            rd(ADDR_CORE_STATUS, 8'h18);
        end
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(ADDR_CONFIG, 8'h1C);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic results();
        $display("Counts: compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_nop();
        t_irq_wake(1'b0);
        t_irq_wake(1'b1);
        t_wdog();
        t_delay(8'h03, 8'h1C, 250, 256);
        t_delay(8'h01, 8'h1D, 1024, 1030);
        t_delay(8'h01, 8'h1F, 1, 4);
        t_reset();
        results();
    end
endmodule
